// ==== hdl/ebcp_pkg.sv ====
package ebcp_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_CS     = 4;
    localparam int ADDR_W     = 24;
    localparam int DATA_W     = 16;
    localparam int REG_ADDR_W = 8;
    localparam int LEN_W      = 6;

    // ==========================================================
    // Register map, byte offsets
    localparam logic [7:0] OFS_CS_TIMING0 = 8'h00;
    localparam logic [7:0] OFS_STATUS     = 8'h10;

    // ==========================================================
    // Timing of the clock and the pins
    localparam int CLK_PERIOD_PS     = 100000;
    localparam int MIN_EDGE_GAP_PS   = 12500;
    localparam bit EDGE_GAP_OK       = (CLK_PERIOD_PS >= MIN_EDGE_GAP_PS);
    // One phase_timing_unit is one system clock
    localparam int PHASE_UNIT_CYCLES = 1;

    // ==========================================================
    // Per chip select timing word, chip_select_timing_ctrl
    typedef struct packed {
        logic       rdy_async;
        logic       rdy_pol;
        logic       rdy_en;
        logic [1:0] hold;
        logic [4:0] access;
        logic       wsetup;
        logic [1:0] cmd;
        logic [1:0] ab_extra;
        logic       ab_sel;
    } ebcp_timing_type;

    localparam logic [15:0] TIMING_RESET = 16'h07c1;
    localparam int          ACCESS_MAX   = 32;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_AB   = 3'b001,
        ST_C    = 3'b010,
        ST_D    = 3'b011,
        ST_E    = 3'b100,
        ST_F    = 3'b101
    } ebcp_state_type;

    // Request from the core side
    typedef struct packed {
        logic                      write;
        logic [1:0]                cs;
        logic [ADDR_W-1:0]         addr;
        logic [DATA_W-1:0]         wdata;
    } ebcp_req_type;

endpackage

// ==== hdl/ebcp_phase_timer.sv ====
`timescale 1ns/10ps
`default_nettype none

module ebcp_phase_timer
    import ebcp_pkg::*;
#(
    parameter int W = LEN_W
) (
    input  wire logic         i_mclk,
    input  wire logic         i_reset,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_len,
    output logic              o_expired
);

    logic [W-1:0] count;

    // Count holds at one so that READY waitstates simply stay expired
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            count <= '0;
        end else if (i_load) begin
            count <= i_len;
        end else if (count > W'(1)) begin
            count <= count - W'(1);
        end
    end

    assign o_expired = (count == W'(1));

endmodule

`default_nettype wire

// ==== hdl/ebcp_bus_sequencer.sv ====
`timescale 1ns/10ps
`default_nettype none

module ebcp_bus_sequencer
    import ebcp_pkg::*;
(
    input  wire logic                  i_mclk,
    input  wire logic                  i_reset,
    input  wire logic [REG_ADDR_W-1:0] i_reg_addr,
    input  wire logic [15:0]           i_reg_wdata,
    input  wire logic                  i_reg_wr,
    input  wire logic                  i_reg_rd,
    output logic      [15:0]           o_reg_rdata,
    input  wire logic                  i_req_valid,
    input  wire ebcp_req_type          i_req,
    output logic                       o_req_ready,
    output logic                       o_done,
    output logic      [DATA_W-1:0]     o_rdata,
    output logic                       o_bus_reference_clock_out,
    output logic      [ADDR_W-1:0]     o_addr,
    output logic      [NUM_CS-1:0]     o_cs_n,
    output logic                       o_ale,
    output logic                       o_rd_n,
    output logic                       o_wr_n,
    input  wire logic [DATA_W-1:0]     i_data,
    output logic      [DATA_W-1:0]     o_data,
    output logic                       o_data_oe_n,
    input  wire logic                  i_ready
);

    // ==========================================================
    // Registers
    ebcp_timing_type             timing [NUM_CS];
    ebcp_state_type              state;
    ebcp_state_type              next_state;
    ebcp_timing_type             cur;
    ebcp_req_type                req;
    logic [1:0]                  last_cs;
    logic                        last_cs_valid;
    logic                        win_change;
    logic [REG_ADDR_W-3:0]       reg_idx;

    assign reg_idx = i_reg_addr[REG_ADDR_W-1:2];

    genvar g;
    generate
        for (g = 0; g < NUM_CS; g++) begin : g_timing
            always_ff @(posedge i_mclk) begin
                if (i_reset) begin
                    timing[g] <= TIMING_RESET;
                end else if (i_reg_wr && i_reg_addr == OFS_CS_TIMING0 + 8'(4 * g)) begin
                    timing[g] <= i_reg_wdata;
                end
            end
        end
    endgenerate

    // Unmapped reads answer zero
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_reg_rdata <= 16'h0000;
        end else if (i_reg_rd) begin
            if (i_reg_addr[1:0] == 2'b00 && reg_idx < NUM_CS) begin
                o_reg_rdata <= timing[reg_idx[1:0]];
            end else if (i_reg_addr == OFS_STATUS) begin
                o_reg_rdata <= {9'h000, last_cs_valid, last_cs, 1'b0, state};
            end else begin
                o_reg_rdata <= 16'h0000;
            end
        end else begin
            o_reg_rdata <= 16'h0000;
        end
    end

    // ==========================================================
    // Pin synchronisers
    logic              rdy_s1;
    logic              rdy_s2;
    logic              rdy_s3;
    logic [DATA_W-1:0] data_s1;
    logic [DATA_W-1:0] data_s2;

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            rdy_s1  <= 1'b0;
            rdy_s2  <= 1'b0;
            rdy_s3  <= 1'b0;
            data_s1 <= '0;
            data_s2 <= '0;
        end else begin
            rdy_s1  <= i_ready;
            rdy_s2  <= rdy_s1;
            rdy_s3  <= rdy_s2;
            data_s1 <= i_data;
            data_s2 <= data_s1;
        end
    end

    // Async mode reads one stage later, costing a waitstate but no timing constraint
    logic rdy_level;
    logic ready_ok;
    assign rdy_level = cur.rdy_async ? rdy_s3 : rdy_s2;
    assign ready_ok  = !cur.rdy_en || (rdy_level == cur.rdy_pol);

    // ==========================================================
    // Phase sequencing
    logic [LEN_W-1:0] len_ab;
    logic [LEN_W-1:0] len_c;
    logic [LEN_W-1:0] len_d;
    logic [LEN_W-1:0] len_e;
    logic [LEN_W-1:0] len_f;
    logic [LEN_W-1:0] next_len;
    logic             expired;
    logic             accept;

    // Address setup is only entered on a take, before cur and req are loaded,
    // so it is sized from the request and its own chip select's word
    assign win_change = !last_cs_valid || (last_cs != i_req.cs);
    assign len_ab = LEN_W'(1) + LEN_W'(timing[i_req.cs].ab_sel)
                  + (win_change ? LEN_W'(timing[i_req.cs].ab_extra) : LEN_W'(0));
    assign len_c  = LEN_W'(cur.cmd);
    assign len_d  = LEN_W'(cur.wsetup);
    assign len_e  = LEN_W'(cur.access) + LEN_W'(1);
    assign len_f  = LEN_W'(cur.hold);

    assign o_req_ready = (state == ST_IDLE);
    assign accept      = o_req_ready && i_req_valid;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (i_req_valid) begin
                    next_state = ST_AB;
                end
            end
            ST_AB: begin
                if (expired) begin
                    next_state = (len_c != 0) ? ST_C : (len_d != 0) ? ST_D : ST_E;
                end
            end
            ST_C: begin
                if (expired) begin
                    next_state = (len_d != 0) ? ST_D : ST_E;
                end
            end
            ST_D: begin
                if (expired) begin
                    next_state = ST_E;
                end
            end
            ST_E: begin
                if (expired && ready_ok) begin
                    next_state = (len_f != 0) ? ST_F : ST_IDLE;
                end
            end
            ST_F: begin
                if (expired) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_comb begin
        case (next_state)
            ST_AB:   next_len = len_ab;
            ST_C:    next_len = len_c;
            ST_D:    next_len = len_d;
            ST_E:    next_len = len_e;
            ST_F:    next_len = len_f;
            default: next_len = '0;
        endcase
    end

    ebcp_phase_timer #(.W(LEN_W)) u_timer (
        .i_mclk    (i_mclk),
        .i_reset   (i_reset),
        .i_load    (next_state != state),
        .i_len     (next_len),
        .o_expired (expired)
    );

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Timing word frozen for the whole cycle, so mid-cycle writes take effect next cycle
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            cur <= TIMING_RESET;
            req <= '0;
        end else if (accept) begin
            cur <= timing[i_req.cs];
            req <= i_req;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            last_cs       <= 2'b00;
            last_cs_valid <= 1'b0;
        end else if (state == ST_AB && next_state != ST_AB) begin
            last_cs       <= req.cs;
            last_cs_valid <= 1'b1;
        end
    end

    // ==========================================================
    // Pins other than the reference clock, registered from the next state; one change per clock at most
    logic in_cycle;
    assign in_cycle = (next_state != ST_IDLE);
    assign o_bus_reference_clock_out = i_mclk;

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_addr      <= '0;
            o_cs_n      <= '1;
            o_ale       <= 1'b0;
            o_rd_n      <= 1'b1;
            o_wr_n      <= 1'b1;
            o_data      <= '0;
            o_data_oe_n <= 1'b1;
        end else begin
            o_addr      <= in_cycle ? (accept ? i_req.addr : req.addr) : o_addr;
            o_cs_n      <= in_cycle ? ~(NUM_CS'(1) << (accept ? i_req.cs : req.cs)) : '1;
            o_ale       <= (next_state == ST_AB);
            o_rd_n      <= !(next_state == ST_E && !req.write);
            o_wr_n      <= !(next_state == ST_E && req.write);
            o_data      <= req.wdata;
            o_data_oe_n <= !(req.write && (next_state == ST_D || next_state == ST_E
                                           || next_state == ST_F));
        end
    end

    // Pin is sampled on the edge that lifts the read strobe; the two-flop
    // synchroniser delivers it two clocks later, so done waits for it
    logic end_p1;
    logic end_p2;
    logic rd_p1;
    logic rd_p2;

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            end_p1  <= 1'b0;
            end_p2  <= 1'b0;
            rd_p1   <= 1'b0;
            rd_p2   <= 1'b0;
            o_rdata <= '0;
            o_done  <= 1'b0;
        end else begin
            end_p1 <= (state == ST_E) && (next_state != ST_E);
            rd_p1  <= !req.write;
            end_p2 <= end_p1;
            rd_p2  <= rd_p1;
            o_done <= end_p2;
            if (end_p2 && rd_p2) begin
                o_rdata <= data_s2;
            end
        end
    end

    // ==========================================================
    // Checks
    logic [LEN_W:0]   phase_cycles;
    logic [LEN_W-1:0] entry_len;

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            phase_cycles <= '0;
            entry_len    <= '0;
        end else if (next_state != state) begin
            phase_cycles <= (LEN_W+1)'(1);
            entry_len    <= next_len;
        end else if (phase_cycles != '1) begin
            phase_cycles <= phase_cycles + (LEN_W+1)'(1);
        end
    end

    sequence seq_access_done;
        state == ST_E && expired && ready_ok;
    endsequence

    sequence seq_access_wait;
        state == ST_E && expired && !ready_ok;
    endsequence

    a_phase_order_ab: assert property (@(posedge i_mclk) disable iff (i_reset)
        state == ST_AB && next_state != ST_AB |=> state inside {ST_C, ST_D, ST_E})
        else $error("address setup not followed by a later phase");
    a_phase_len_fixed: assert property (@(posedge i_mclk) disable iff (i_reset)
        state inside {ST_AB, ST_C, ST_D, ST_F} && next_state != state
        |-> phase_cycles == {1'b0, entry_len})
        else $error("phase did not last its programmed length");
    a_ab_len_range: assert property (@(posedge i_mclk) disable iff (i_reset)
        state == ST_AB && next_state != ST_AB |-> phase_cycles >= 1 && phase_cycles <= 5)
        else $error("address setup length out of range");
    a_access_min_len: assert property (@(posedge i_mclk) disable iff (i_reset)
        state == ST_E && next_state != ST_E |-> phase_cycles >= {1'b0, entry_len})
        else $error("access phase shorter than programmed");
    a_ready_waitstate: assert property (@(posedge i_mclk) disable iff (i_reset)
        seq_access_wait |=> state == ST_E && expired)
        else $error("access ended while ready inactive");
    a_ready_terminate: assert property (@(posedge i_mclk) disable iff (i_reset)
        seq_access_done |=> state inside {ST_F, ST_IDLE} ##2 o_done)
        else $error("access not ended on ready");
    a_async_extra_stage: assert property (@(posedge i_mclk) disable iff (i_reset)
        cur.rdy_async && cur.rdy_en |-> rdy_level == $past(rdy_s2))
        else $error("async ready skipped its extra stage");
    a_cmd_in_access: assert property (@(posedge i_mclk) disable iff (i_reset)
        !o_rd_n || !o_wr_n |-> $past(state) == ST_E || state == ST_E)
        else $error("command strobe outside the access phase");
    a_read_latch: assert property (@(posedge i_mclk) disable iff (i_reset)
        state == ST_E && next_state != ST_E && !req.write |=> o_rd_n ##2 o_rdata == $past(i_data, 3))
        else $error("read data not latched at strobe end");
    a_edge_gap: assert property (@(posedge i_mclk) disable iff (i_reset)
        EDGE_GAP_OK && PHASE_UNIT_CYCLES >= 1)
        else $error("clock too fast for the pin drivers");
    a_cfg_from_cs: assert property (@(posedge i_mclk) disable iff (i_reset)
        accept |=> cur == $past(timing[i_req.cs]))
        else $error("timing word not taken from the selected chip select");
    a_short_phase_len: assert property (@(posedge i_mclk) disable iff (i_reset)
        state == ST_AB |-> len_c <= 3 && len_d <= 1)
        else $error("command or data setup length out of range");

endmodule

`default_nettype wire

// ==== sim/ebcp_ext_mem.sv ====
`timescale 1ns/10ps
`default_nettype none

module ebcp_ext_mem
    import ebcp_pkg::*;
(
    input  wire logic              i_mclk,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [NUM_CS-1:0] i_cs_n,
    input  wire logic              i_rd_n,
    input  wire logic              i_wr_n,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_oe_n,
    input  wire logic              i_rdy_pol,
    input  wire logic [3:0]        i_rdy_wait,
    output logic      [DATA_W-1:0] o_data,
    output logic                   o_ready
);
    logic [DATA_W-1:0] mem [8];
    logic [DATA_W-1:0] last = 16'h0000;
    logic [3:0]        cnt  = 4'h0;
    logic              sel;
    logic              cmd;
    logic              rdy;

    assign sel = ~&i_cs_n;
    assign cmd = ~i_rd_n | ~i_wr_n;
    // Released bus toggles every cycle so a stale sample never looks valid
    assign o_data = (sel && i_oe_n) ? mem[i_addr[2:0]] : ~last;
    // Ready follows the reference clock and waits on the command strobe
    assign rdy = cmd && (cnt >= i_rdy_wait);
    assign o_ready = i_rdy_pol ? rdy : ~rdy;

    always @(posedge i_mclk) begin
        last <= o_data;
        cnt  <= cmd ? ((cnt == 4'hf) ? cnt : cnt + 4'h1) : 4'h0;
        if (sel && !i_wr_n && !i_oe_n) begin
            mem[i_addr[2:0]] <= i_wdata;
        end
    end
endmodule

`default_nettype wire

// ==== sim/external_bus_cycle_phases_tb.sv ====
`timescale 1ns/10ps
`default_nettype none

module external_bus_cycle_phases_tb;
    import ebcp_pkg::*;
    logic                  i_mclk = 1'b0;
    logic                  i_reset = 1'b1;
    logic [REG_ADDR_W-1:0] i_reg_addr = 8'h00;
    logic [15:0]           i_reg_wdata = 16'h0000;
    logic                  i_reg_wr = 1'b0;
    logic                  i_reg_rd = 1'b0;
    logic                  i_req_valid = 1'b0;
    ebcp_req_type          i_req = '0;
    logic [15:0]           o_reg_rdata, o_rdata, o_data, pin_data;
    logic                  o_req_ready, o_done, o_ref, o_ale, o_rd_n, o_wr_n, o_oe_n, pin_ready;
    logic [ADDR_W-1:0]     o_addr;
    logic [NUM_CS-1:0]     o_cs_n;
    logic                  rdy_pol = 1'b1;
    logic [3:0]            rdy_wait = 4'h0;
    int                    n_errors = 0;
    int                    samples_checked = 0;
    int                    exp_mem [8];

    // ==========================================================
    // Clock, parts
    initial begin
        forever #50 i_mclk = ~i_mclk;
    end

    ebcp_bus_sequencer uut (.i_mclk(i_mclk), .i_reset(i_reset), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
        .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_done(o_done),
        .o_rdata(o_rdata), .o_bus_reference_clock_out(o_ref), .o_addr(o_addr), .o_cs_n(o_cs_n),
        .o_ale(o_ale), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n), .i_data(pin_data), .o_data(o_data),
        .o_data_oe_n(o_oe_n), .i_ready(pin_ready));

    ebcp_ext_mem mem_i (.i_mclk(i_mclk), .i_addr(o_addr), .i_cs_n(o_cs_n), .i_rd_n(o_rd_n),
        .i_wr_n(o_wr_n), .i_wdata(o_data), .i_oe_n(o_oe_n), .i_rdy_pol(rdy_pol),
        .i_rdy_wait(rdy_wait), .o_data(pin_data), .o_ready(pin_ready));

    // ==========================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("errors=%0d checks=%0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_mclk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge i_mclk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        #1;
        d = o_reg_rdata;
    endtask

    // Latency counts edges from the take to o_done; gap is the hold phase, from busy cycles
    task automatic xfer(input logic wr, input logic [1:0] cs, input logic [2:0] idx,
                        input logic [15:0] wd, output int lat, output int gap, output logic [15:0] rd);
        int k;
        int busy;
        @(posedge i_mclk);
        i_req_valid <= 1'b1;
        i_req <= {wr, cs, 21'($urandom), idx, wd};
        #1;
        k = 0;
        while (o_req_ready !== 1'b1 && k < 100) begin
            @(posedge i_mclk);
            #1;
            k++;
        end
        @(posedge i_mclk);
        i_req_valid <= 1'b0;
        lat = 0;
        busy = 0;
        do begin
            @(posedge i_mclk);
            #1;
            lat++;
            if (o_req_ready !== 1'b1) busy++;
        end while (o_done !== 1'b1 && lat < 500);
        rd = o_rdata;
        while (o_req_ready !== 1'b1 && busy < 600) begin
            @(posedge i_mclk);
            #1;
            if (o_req_ready !== 1'b1) busy++;
        end
        // Busy samples cover all phases less the take cycle; done trails access by two
        gap = busy - lat + 3;
    endtask

    // ==========================================================
    // Sequence
    initial begin
        logic [15:0]     d, t, wd;
        logic [1:0]      cs, prev;
        logic [2:0]      idx;
        logic            wr;
        int              lat, gap, exp_lat, sync_lat [2];
        void'($urandom(26));
        repeat (16) @(posedge i_mclk);
        i_reset <= 1'b0;
        for (int c = 0; c < NUM_CS; c++) begin
            reg_rd(8'(4 * c), d);
            check(d, TIMING_RESET);
        end
        reg_rd(OFS_STATUS, d);
        check(d, 16'h0000);
        reg_rd(8'h20, d);
        check(d, 16'h0000);
        check(EDGE_GAP_OK, 1);
        @(posedge i_mclk);
        #1;
        check(o_ref, 1);
        @(negedge i_mclk);
        #1;
        check(o_ref, 0);
        reg_wr(OFS_CS_TIMING0, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            exp_mem[i] = 32'($urandom) & 32'hffff;
            xfer(1'b1, 2'h0, 3'(i), 16'(exp_mem[i]), lat, gap, d);
            check(lat, 4);
        end
        prev = 2'h0;
        for (int i = 0; i < 40; i++) begin
            cs = 2'($urandom);
            t = 16'($urandom) & 16'h1fff;
            if (i == 0) t[10:6] = 5'h00;
            if (i == 1) t[10:6] = 5'h1f;
            reg_wr(8'(4 * cs), t);
            reg_rd(8'(4 * cs), d);
            check(d, t);
            wr = 1'($urandom);
            idx = 3'($urandom);
            wd = 16'($urandom);
            xfer(wr, cs, idx, wd, lat, gap, d);
            exp_lat = (t[0] ? 2 : 1) + ((cs != prev) ? int'(t[2:1]) : 0) + int'(t[4:3]) + int'(t[5])
                    + int'(t[10:6]) + 3;
            check(lat, exp_lat);
            check(gap, t[12:11]);
            if (wr) exp_mem[idx] = wd;
            else check(d, exp_mem[idx]);
            prev = cs;
        end
        rdy_wait <= 4'h5;
        for (int m = 0; m < 4; m++) begin
            rdy_pol <= m[0];
            t = {m[1], m[0], 1'b1, 13'h0000};
            reg_wr(8'h04, t);
            xfer(1'b0, 2'h1, 3'h3, 16'h0000, lat, gap, d);
            check(d, exp_mem[3]);
            check(lat > 7 && lat < 18, 1);
            if (m < 2) sync_lat[m] = lat;
            else check(lat > sync_lat[m - 2], 1);
        end
        finish_test();
    end

    initial begin
        #5000000;
        n_errors++;
        finish_test();
    end
endmodule

`default_nettype wire
